// ---- tca_cache_access.sv ----
// Cache-based access path to a content lookup memory, with APB registers
//
// What this block does
// (RULE1) Cache registers 32-bit, 64 words, sparse backing
// (RULE2) Only low 384 entry/mask bits stored
// (RULE3) Software fills data, mask, type-group
// (RULE4) Untyped entries start data at bit 0
// (RULE5) Type bits normally left unmasked
// (RULE6) Two subwords: bits 0-187 and 188-375
// (RULE7) 188-bit subwords leave half-row bits unused
// (RULE8) Type-group per subword, packed back-to-back
// (RULE9) Type-group zero never matches
// (RULE10) Software writes action with type prefix
// (RULE11) Action subwords concatenated like entry
// (RULE12) Source-address action holds four subwords
// (RULE13) One counter per subword, concatenated
// (RULE14) Trigger starts copy; hardware clears it
// (RULE15) No new operation until trigger clears
// (RULE16) Copy latency varies; poll the trigger
// (RULE17) Three flags skip entry, action, counter
// (RULE18) Memory-to-cache load uses same handshake
// (RULE19) Masked one reads back as masked zero
// (RULE20) Whole entry always moved at once
// (RULE21) Cache holds one entry at a time
// (RULE22) Leave cache alone while trigger set
`timescale 1ns/1ps
module tca_cache_access (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lookup port
    input wire logic lookup_valid,
    input wire logic [2:0] lookup_tg,
    input wire logic [383:0] lookup_key,
    output logic lookup_hit,
    output logic [5:0] lookup_row,
    output logic [1:0] lookup_subword,
    output logic [98:0] lookup_action,
    // Status
    output logic copy_busy
);
    localparam int EB = tca_pkg::ENTRY_BITS;
    localparam int AB = tca_pkg::ACTION_BITS;
    localparam int TGW = tca_pkg::TG_ALL;
    localparam int CW = tca_pkg::CNT_ALL;
    localparam int RW = tca_pkg::ADDR_BITS;

    typedef struct packed {
        logic [tca_pkg::ROWS-1:0][EB-1:0] mem_data;
        logic [tca_pkg::ROWS-1:0][EB-1:0] mem_mask;
        logic [tca_pkg::ROWS-1:0][TGW-1:0] mem_tg;
        logic [tca_pkg::ROWS-1:0][AB-1:0] mem_act;
        logic [tca_pkg::ROWS-1:0][CW-1:0] mem_cnt;
        logic [EB-1:0] cache_data;
        logic [EB-1:0] cache_mask;
        logic [AB-1:0] cache_act;
        logic [CW-1:0] cache_cnt;
        logic [TGW-1:0] cache_tg;
        logic cmd;
        logic shot;
        logic skip_entry;
        logic skip_action;
        logic skip_cnt;
        logic [RW-1:0] addr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic hit;
        logic [RW-1:0] hit_row;
        logic [1:0] hit_sw;
        logic [AB-1:0] hit_act;
    } tca_state_t;

    tca_state_t s_q;
    tca_state_t s_d;
    logic start_w;
    logic fire_w;
    logic [31:0] rd_w;
    logic err_w;
    logic [31:0] ctrl_w;
    int wi;
    int sw_w;
    int hr;
    int hs;
    logic hit_f;

    // Read one 32-bit word of a wide vector; bits past nbits read 0
    function automatic logic [31:0] get_word(input logic [EB-1:0] v,
                                             input int idx,
                                             input int nbits);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < tca_pkg::WORD_BITS; i++) begin
            if (idx * tca_pkg::WORD_BITS + i < nbits) begin
                w[i] = v[idx * tca_pkg::WORD_BITS + i];
            end
        end
        return w;
    endfunction

    // Replace one word; bits with no backing storage are dropped
    function automatic logic [EB-1:0] put_word(input logic [EB-1:0] v,
                                               input int idx,
                                               input logic [31:0] w,
                                               input int nbits);
        logic [EB-1:0] r;
        r = v;
        for (int i = 0; i < tca_pkg::WORD_BITS; i++) begin
            if (idx * tca_pkg::WORD_BITS + i < nbits) begin
                r[idx * tca_pkg::WORD_BITS + i] = w[i];
            end
        end
        return r;
    endfunction

    // Subword width for a type-group size, zero when none
    function automatic int sw_width(input logic [2:0] tg);
        int w;
        w = 0;
        case (tg)
            tca_pkg::TG_FULL: w = tca_pkg::FULL_BITS;
            tca_pkg::TG_HALF: w = tca_pkg::HALF_BITS; // see (RULE6)
            tca_pkg::TG_QUARTER: w = tca_pkg::QUARTER_BITS;
            default: w = 0;
        endcase
        return w;
    endfunction

    // Ternary compare of one subword against a key in its low bits
    function automatic logic sw_match(input logic [EB-1:0] data,
                                      input logic [EB-1:0] mask,
                                      input logic [EB-1:0] key,
                                      input int sw,
                                      input int w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < EB; i++) begin
            if (i < w && !mask[sw * w + i]) begin // see (RULE7)
                if (data[sw * w + i] != key[i]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    // Paces each copy; counts only cycles with no lookup
    tca_copy_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_w),
        .stall(lookup_valid),
        .fire(fire_w)
    );

    // Current control word as software sees it
    always_comb begin
        ctrl_w = tca_pkg::CTRL_RESET;
        ctrl_w[tca_pkg::CTRL_CMD_BIT] = s_q.cmd;
        ctrl_w[tca_pkg::CTRL_SHOT_BIT] = s_q.shot; // see (RULE16)
        ctrl_w[tca_pkg::CTRL_SKIP_ENTRY_BIT] = s_q.skip_entry;
        ctrl_w[tca_pkg::CTRL_SKIP_ACTION_BIT] = s_q.skip_action;
        ctrl_w[tca_pkg::CTRL_SKIP_CNT_BIT] = s_q.skip_cnt;
        ctrl_w[tca_pkg::CTRL_ADDR_LSB +: RW] = s_q.addr;
    end

    // Address decode and read mux; 64 words per cache region
    always_comb begin
        wi = int'(paddr[7:2]);
        rd_w = '0;
        err_w = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            err_w = 1'b1;
        end else if (paddr[11:8] == tca_pkg::OFF_ENTRY[11:8]) begin
            rd_w = get_word(s_q.cache_data, wi, EB); // see (RULE1)
        end else if (paddr[11:8] == tca_pkg::OFF_MASK[11:8]) begin
            rd_w = get_word(s_q.cache_mask, wi, EB); // see (RULE2)
        end else if (paddr[11:8] == tca_pkg::OFF_ACTION[11:8]) begin
            rd_w = get_word(EB'(s_q.cache_act), wi, AB);
        end else if (paddr[11:8] == tca_pkg::OFF_COUNTER[11:8]) begin
            rd_w = get_word(EB'(s_q.cache_cnt), wi, CW); // see (RULE13)
        end else if (paddr == tca_pkg::OFF_TG) begin
            rd_w = get_word(EB'(s_q.cache_tg), 0, TGW); // see (RULE8)
        end else if (paddr == tca_pkg::OFF_CTRL) begin
            rd_w = ctrl_w;
        end else begin
            err_w = 1'b1;
        end
    end

    // First matching row and subword of a lookup, lowest row wins
    always_comb begin
        hit_f = 1'b0;
        hr = 0;
        hs = 0;
        sw_w = sw_width(lookup_tg);
        if (lookup_valid && sw_w != 0) begin
            for (int r = tca_pkg::ROWS - 1; r >= 0; r--) begin
                for (int sw = tca_pkg::SUBWORDS - 1; sw >= 0; sw--) begin
                    // Group zero never equals a valid key group
                    if ((sw + 1) * sw_w <= EB &&
                        s_q.mem_tg[r][sw * tca_pkg::TG_BITS +:
                                      tca_pkg::TG_BITS] == lookup_tg &&
                        sw_match(s_q.mem_data[r], s_q.mem_mask[r],
                                 lookup_key, sw, sw_w)) begin // see (RULE9)
                        hit_f = 1'b1;
                        hr = r;
                        hs = sw;
                    end
                end
            end
        end
    end

    // Next state: APB access, lookup results, copy between cache and memory
    always_comb begin
        s_d = s_q;
        start_w = 1'b0;

        // One wait state: answer is prepared, then completes
        s_d.pready = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.prdata = pwrite ? 32'h0000_0000 : rd_w;
            s_d.pslverr = err_w;
        end

        // Writes land on the completing edge of the access
        if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
            if (paddr == tca_pkg::OFF_CTRL) begin
                if (!s_q.shot) begin // see (RULE15)
                    s_d.cmd = pwdata[tca_pkg::CTRL_CMD_BIT];
                    s_d.skip_entry = pwdata[tca_pkg::CTRL_SKIP_ENTRY_BIT];
                    s_d.skip_action = pwdata[tca_pkg::CTRL_SKIP_ACTION_BIT];
                    s_d.skip_cnt = pwdata[tca_pkg::CTRL_SKIP_CNT_BIT];
                    s_d.addr = pwdata[tca_pkg::CTRL_ADDR_LSB +: RW];
                    if (pwdata[tca_pkg::CTRL_SHOT_BIT]) begin
                        s_d.shot = 1'b1; // see (RULE14)
                        start_w = 1'b1;
                    end
                end
            end else if (!s_q.shot) begin
                // Cache is frozen during a copy to keep the entry whole
                if (paddr[11:8] == tca_pkg::OFF_ENTRY[11:8]) begin
                    s_d.cache_data = put_word(s_q.cache_data, wi,
                                              pwdata, EB); // see (RULE2)
                end else if (paddr[11:8] == tca_pkg::OFF_MASK[11:8]) begin
                    s_d.cache_mask = put_word(s_q.cache_mask, wi,
                                              pwdata, EB);
                end else if (paddr[11:8] == tca_pkg::OFF_ACTION[11:8]) begin
                    s_d.cache_act = AB'(put_word(EB'(s_q.cache_act), wi,
                                                 pwdata, AB)); // see (RULE11)
                end else if (paddr[11:8] == tca_pkg::OFF_COUNTER[11:8]) begin
                    s_d.cache_cnt = CW'(put_word(EB'(s_q.cache_cnt), wi,
                                                 pwdata, CW)); // see (RULE13)
                end else if (paddr == tca_pkg::OFF_TG) begin
                    s_d.cache_tg = TGW'(put_word(EB'(s_q.cache_tg), 0,
                                                 pwdata, TGW)); // see (RULE8)
                end
            end
        end

        // Lookup result and hit counting per subword
        s_d.hit = hit_f;
        if (hit_f) begin
            s_d.hit_row = RW'(hr);
            s_d.hit_sw = 2'(hs);
            s_d.hit_act = s_q.mem_act[hr]; // see (RULE12)
            s_d.mem_cnt[hr][hs * tca_pkg::CNT_BITS +: tca_pkg::CNT_BITS] =
                s_q.mem_cnt[hr][hs * tca_pkg::CNT_BITS +: tca_pkg::CNT_BITS]
                + 32'h0000_0001; // see (RULE13)
        end

        // Whole-entry copy; a copied counter overrides a same-cycle hit
        if (fire_w) begin
            if (!s_q.cmd) begin
                if (!s_q.skip_entry) begin // see (RULE17)
                    s_d.mem_data[s_q.addr] = s_q.cache_data; // see (RULE20)
                    s_d.mem_mask[s_q.addr] = s_q.cache_mask;
                    s_d.mem_tg[s_q.addr] = s_q.cache_tg;
                end
                if (!s_q.skip_action) begin // see (RULE17)
                    s_d.mem_act[s_q.addr] = s_q.cache_act;
                end
                if (!s_q.skip_cnt) begin // see (RULE17)
                    s_d.mem_cnt[s_q.addr] = s_q.cache_cnt;
                end
            end else begin
                if (!s_q.skip_entry) begin // see (RULE18)
                    // Don't-care bits come back as zero
                    s_d.cache_data = s_q.mem_data[s_q.addr] &
                                     ~s_q.mem_mask[s_q.addr]; // see (RULE19)
                    s_d.cache_mask = s_q.mem_mask[s_q.addr];
                    s_d.cache_tg = s_q.mem_tg[s_q.addr];
                end
                if (!s_q.skip_action) begin
                    s_d.cache_act = s_q.mem_act[s_q.addr];
                end
                if (!s_q.skip_cnt) begin
                    s_d.cache_cnt = s_q.mem_cnt[s_q.addr];
                end
            end
            s_d.shot = 1'b0; // see (RULE14)
        end
    end

    // State register; memory and cache clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign lookup_hit = s_q.hit;
    assign lookup_row = s_q.hit_row;
    assign lookup_subword = s_q.hit_sw;
    assign lookup_action = s_q.hit_act;
    assign copy_busy = s_q.shot;
endmodule

// ---- tca_cache_access_bench.sv ----
// Self-checking bench for the lookup cache access block
`timescale 1ns/1ps
module tca_cache_access_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, lookup_hit, copy_busy;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, d, a_dat, m_dat, act2;
    logic lookup_valid = 1'b0, lv_seen = 1'b0;
    logic [2:0] lookup_tg = 3'h0;
    logic [383:0] lookup_key = '0, k;
    logic [5:0] lookup_row;
    logic [1:0] lookup_subword;
    logic [98:0] lookup_action;
    logic [33:0] q_apb[$];
    logic [8:0] q_lk[$];
    logic [11:0] bad[3] = '{12'h002, 12'h408, 12'h7fc};
    int fail_count = 0, samples_checked = 0, cycles = 0;

    // Half-period toggle gives 5 ns
    always #2.5 pclk = ~pclk;

    tca_cache_access DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lookup_valid(lookup_valid),
        .lookup_tg(lookup_tg), .lookup_key(lookup_key),
        .lookup_hit(lookup_hit), .lookup_row(lookup_row),
        .lookup_subword(lookup_subword), .lookup_action(lookup_action),
        .copy_busy(copy_busy));

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_apb(input logic [32:0] got, input logic [32:0] e);
        samples_checked++;
        if (got !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic cmp_lk(input logic [8:0] got, input logic [8:0] e);
        samples_checked++;
        if (got !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // One APB transfer; the note says whether read data counts
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [32:0] e,
                       input logic cd);
        q_apb.push_back({cd, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(negedge pclk); while (pready !== 1'b1);
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 33'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, 1'b1);
    endtask

    // Start a copy and poll busy; latency is not fixed
    task automatic copy(input logic cmd, input logic [2:0] skip,
                        input logic [5:0] row);
        wr(tca_pkg::OFF_CTRL, {10'h0, row, 11'h0, skip, 1'b1, cmd});
        do @(negedge pclk); while (copy_busy !== 1'b0);
        @(posedge pclk);
    endtask

    task automatic look(input logic [2:0] tg, input logic [383:0] key,
                        input logic [8:0] e);
        q_lk.push_back(e);
        lookup_valid <= 1'b1;
        lookup_tg <= tg;
        lookup_key <= key;
        @(posedge pclk);
        lookup_valid <= 1'b0;
        @(posedge pclk);
    endtask

    // Watcher: oldest note against each result; pre-edge values
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (q_apb.size() == 0) cmp_apb(33'h1, 33'h0);
            else if (q_apb[0][33]) cmp_apb({pslverr, prdata}, q_apb.pop_front());
            else cmp_apb({pslverr, 32'h0}, {q_apb.pop_front() >> 32, 32'h0});
        end
        if (lv_seen) begin
            if (q_lk[0][8]) cmp_apb({1'b0, lookup_action[31:0]}, {1'b0, act2});
            if (q_lk[0][8]) cmp_lk({lookup_hit, lookup_row, lookup_subword}, q_lk.pop_front());
            else cmp_lk({lookup_hit, 8'h0}, q_lk.pop_front());
        end
        lv_seen <= lookup_valid;
    end

    // Hang guard well above the expected run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h4af79c4a));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(tca_pkg::OFF_CTRL, tca_pkg::CTRL_RESET);
        // Unbacked words and bits read as zero
        for (int i = 0; i < 13; i++) begin
            d = $urandom;
            wr(tca_pkg::OFF_ENTRY + 12'(4 * i), d);
            rd(tca_pkg::OFF_ENTRY + 12'(4 * i), i < 12 ? d : 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(tca_pkg::OFF_ACTION + 12'(4 * i), d);
            rd(tca_pkg::OFF_ACTION + 12'(4 * i), i < 3 ? d : {29'h0, d[2:0]});
            wr(tca_pkg::OFF_COUNTER + 12'(4 * i), d);
            rd(tca_pkg::OFF_COUNTER + 12'(4 * i), d);
        end
        wr(tca_pkg::OFF_TG, d);
        rd(tca_pkg::OFF_TG, {20'h0, d[11:0]});
        for (int i = 0; i < 3; i++) apb(i[0], bad[i], d, 33'h1_0000_0000, 1'b0);
        // Entry with masked ones, full type-group, cleared counter
        a_dat = $urandom | 32'h0000_00f0;
        m_dat = 32'h0f0f_0ff0;
        act2 = $urandom;
        wr(tca_pkg::OFF_ENTRY, a_dat);
        wr(tca_pkg::OFF_MASK, m_dat);
        for (int i = 1; i < 12; i++) wr(tca_pkg::OFF_MASK + 12'(4 * i), '1);
        wr(tca_pkg::OFF_TG, {29'h0, tca_pkg::TG_FULL});
        wr(tca_pkg::OFF_COUNTER, 32'h0);
        copy(1'b0, 3'h0, 6'd5);
        wr(tca_pkg::OFF_ENTRY, ~a_dat);
        wr(tca_pkg::OFF_ACTION, act2);
        copy(1'b0, 3'h1, 6'd5);
        wr(tca_pkg::OFF_ACTION, ~act2);
        // Restore the entry so only the action and counter are skipped
        wr(tca_pkg::OFF_ENTRY, a_dat);
        copy(1'b0, 3'h6, 6'd5);
        // Masked key bits are random; bit 0 is exact
        for (int i = 0; i < 12; i++) k[32 * i +: 32] = $urandom;
        k[31:0] = (a_dat & ~m_dat) | (k[31:0] & m_dat);
        look(tca_pkg::TG_FULL, k, {1'b1, 6'd5, 2'd0});
        look(tca_pkg::TG_FULL, k ^ 384'h1, 9'h0);
        look(tca_pkg::TG_HALF, k, 9'h0);
        look(3'h0, k, 9'h0);
        look(tca_pkg::TG_FULL, k, {1'b1, 6'd5, 2'd0});
        copy(1'b1, 3'h0, 6'd5);
        rd(tca_pkg::OFF_ENTRY, a_dat & ~m_dat);
        rd(tca_pkg::OFF_MASK, m_dat);
        rd(tca_pkg::OFF_ACTION, act2);
        rd(tca_pkg::OFF_COUNTER, 32'h2);
        rd(tca_pkg::OFF_TG, 32'h1);
        copy(1'b1, 3'h0, 6'd6);
        rd(tca_pkg::OFF_TG, 32'h0);
        repeat (4) @(posedge pclk);
        close_out();
    end
endmodule

// ---- tca_cache_access_chk.sv ----
// Port checker for the lookup cache access block
`timescale 1ns/1ps
module tca_cache_access_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Lookup and status
    input wire logic lookup_valid,
    input wire logic [2:0] lookup_tg,
    input wire logic lookup_hit,
    input wire logic copy_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase still waiting for the slave
    wire acc = psel && penable && !pready;
    // Completing write that sets the trigger, busy or idle
    wire go = psel && pready && pwrite && paddr == 12'h404 && pwdata[1];

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_follows: assert property (acc |=> pready)
        else $error("pready missing after access phase");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access");
    a_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned access not refused");
    a_err_range: assert property (acc && paddr > 12'h404 |=> pslverr)
        else $error("unmapped access not refused");
    a_ok_cache: assert property (acc && paddr[1:0] == 2'h0 && paddr < 12'h400 |=> !pslverr)
        else $error("cache access refused");
    a_busy_start: assert property (go && !copy_busy |=> copy_busy)
        else $error("trigger did not start a copy");
    a_busy_hold: assert property ($rose(copy_busy) |-> copy_busy[*4])
        else $error("copy ended too early");
    a_busy_ends: assert property ($rose(copy_busy) |-> ##[1:200] !copy_busy)
        else $error("trigger never cleared");
    a_tg_zero: assert property (lookup_valid && lookup_tg == 3'h0 |=> !lookup_hit)
        else $error("hit on type-group zero");
    a_hit_cause: assert property (lookup_hit |-> $past(lookup_valid))
        else $error("hit without a lookup");
endmodule

bind tca_cache_access tca_cache_access_chk u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .lookup_valid(lookup_valid), .lookup_tg(lookup_tg),
    .lookup_hit(lookup_hit), .copy_busy(copy_busy));

// ---- tca_copy_timer.sv ----
// Copy sequencer: paces a cache copy and yields to lookup traffic
`timescale 1ns/1ps
module tca_copy_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic stall,
    output logic fire
);
    typedef struct packed {
        tca_pkg::tca_copy_state_t state;
        logic [7:0] cnt;
        logic fire;
    } tca_timer_t;

    localparam logic [7:0] LAST = 8'(tca_pkg::COPY_CYCLES - 1);

    tca_timer_t s_q;
    tca_timer_t s_d;

    // Count only cycles free of lookups, so latency follows load
    always_comb begin
        s_d = s_q;
        s_d.fire = 1'b0;
        case (s_q.state)
            tca_pkg::TCA_IDLE: begin
                if (start) begin
                    s_d.cnt = 8'h00;
                    s_d.state = tca_pkg::TCA_RUN;
                end
            end
            tca_pkg::TCA_RUN: begin
                if (!stall) begin // see (RULE16)
                    if (s_q.cnt == LAST) begin
                        s_d.fire = 1'b1;
                        s_d.state = tca_pkg::TCA_IDLE;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
            end
            default: s_d.state = tca_pkg::TCA_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fire = s_q.fire;
endmodule

// ---- tca_pkg.sv ----
// Constants and types shared by the lookup cache access block
package tca_pkg;
    // Lookup memory geometry
    localparam int ROWS = 64;
    localparam int ADDR_BITS = 6;
    localparam int ENTRY_BITS = 384;
    localparam int ACTION_BITS = 99;
    localparam int SUBWORDS = 4;
    localparam int CNT_BITS = 32;
    localparam int TG_BITS = 3;
    localparam int TG_ALL = SUBWORDS * TG_BITS;
    localparam int CNT_ALL = SUBWORDS * CNT_BITS;
    localparam int WORD_BITS = 32;
    // Subword widths for each type-group size
    localparam int FULL_BITS = 384;
    localparam int HALF_BITS = 188;
    localparam int QUARTER_BITS = 94;
    localparam logic [2:0] TG_FULL = 3'h1;
    localparam logic [2:0] TG_HALF = 3'h2;
    localparam logic [2:0] TG_QUARTER = 3'h3;
    // APB byte offsets of the register regions
    localparam logic [11:0] OFF_ENTRY = 12'h000;
    localparam logic [11:0] OFF_MASK = 12'h100;
    localparam logic [11:0] OFF_ACTION = 12'h200;
    localparam logic [11:0] OFF_COUNTER = 12'h300;
    localparam logic [11:0] OFF_TG = 12'h400;
    localparam logic [11:0] OFF_CTRL = 12'h404;
    // Fields of copy_control
    localparam int CTRL_CMD_BIT = 0;
    localparam int CTRL_SHOT_BIT = 1;
    localparam int CTRL_SKIP_ENTRY_BIT = 2;
    localparam int CTRL_SKIP_ACTION_BIT = 3;
    localparam int CTRL_SKIP_CNT_BIT = 4;
    localparam int CTRL_ADDR_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Copy latency
    localparam int CLK_PERIOD_NS = 5;
    localparam int COPY_MIN_NS = 20;
    localparam int COPY_CYCLES =
        (COPY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Copy sequencer states
    typedef enum logic [0:0] {TCA_IDLE, TCA_RUN} tca_copy_state_t;
endpackage
